//--- dv/csf_status_bank_map_asserts.sv
// port assertions for the status flags and bank map
`timescale 1ns/1ps
module csf_status_bank_map_asserts (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       other_reset,
  input wire logic                       watchdog_clear_instr,
  input wire logic                       sleep_instr,
  input wire logic                       watchdog_timer_expired,
  input wire logic [csf_pkg::ADDR_W-1:0] mem_addr,
  input wire logic                       mem_wr,
  input wire logic [7:0]                 mem_wdata,
  input wire logic [7:0]                 mem_rdata,
  input wire logic                       alu_valid,
  input wire csf_pkg::csf_op_t           alu_op,
  input wire logic                       alu_upd_zero,
  input wire logic                       alu_upd_carries,
  input wire logic [7:0]                 alu_opa,
  input wire logic [7:0]                 alu_opb,
  input wire logic [7:0]                 alu_result,
  input wire logic [7:0]                 arith_reset_flags
);
  logic       is_sub, ev, hold, unimpl;
  logic [7:0] opb_x;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [1:0] up_q;
  assign is_sub = alu_op == csf_pkg::CSF_OP_SUB;
  assign opb_x  = is_sub ? ~alu_opb : alu_opb;
  assign sum9   = {1'b0, alu_opa} + {1'b0, opb_x} + {8'h00, is_sub};
  assign sum5   = {1'b0, alu_opa[3:0]} + {1'b0, opb_x[3:0]} + {4'h0, is_sub};
  assign ev     = watchdog_clear_instr | sleep_instr | watchdog_timer_expired | other_reset;
  assign hold   = up_q[1] & !mem_wr & !alu_valid & !ev & (mem_addr[6:0] == csf_pkg::OFS_STATUS);
  assign unimpl = mem_addr[6:0] inside {[csf_pkg::OFS_PERI_FIRST:csf_pkg::OFS_PERI_LAST]}
    || (mem_addr[11:7] >= csf_pkg::GPR_BANKS && mem_addr[6:0] >= csf_pkg::OFS_GPR_FIRST
    && mem_addr[6:0] <= csf_pkg::OFS_GPR_LAST);
  // synchronised reset release takes two edges
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_q <= 2'h0;
    end
    else
    begin
      up_q <= {up_q[0], 1'b1};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_hold_status; hold [*2]; endsequence
  sequence s_status_wr; mem_wr && mem_addr[6:0] == csf_pkg::OFS_STATUS && !alu_valid && !ev;
  endsequence
  property p_upper_zero; arith_reset_flags[7:5] == 3'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper status bits set");
  property p_sleep; sleep_instr && !watchdog_timer_expired && !other_reset
    |=> arith_reset_flags[4:3] == 2'h2; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
  property p_expire; watchdog_timer_expired && !other_reset |=> !arith_reset_flags[4];
  endproperty
  a_expire: assert property (p_expire) else $error("timeout flag not cleared");
  property p_zero; alu_valid && alu_upd_zero |=> arith_reset_flags[2] == (alu_result == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_arith; alu_valid && alu_upd_carries && alu_op != csf_pkg::CSF_OP_LOGIC
    |=> arith_reset_flags[1:0] == {$past(sum5[4]), $past(sum9[8])}
    && alu_result == $past(sum9[7:0]); endproperty
  a_arith: assert property (p_arith) else $error("carry flags wrong");
  property p_status_wr; s_status_wr
    |=> arith_reset_flags[4:0] == {$past(arith_reset_flags[4:3]), $past(mem_wdata[2:0])};
  endproperty
  a_status_wr: assert property (p_status_wr) else $error("status write wrong");
  property p_hold; s_hold_status |=> mem_rdata == $past(arith_reset_flags); endproperty
  a_hold: assert property (p_hold) else $error("status read wrong");
  property p_unimpl; unimpl |=> mem_rdata == 8'h00; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented read");
endmodule : csf_status_bank_map_asserts

bind csf_status_bank_map csf_status_bank_map_asserts i_csf_status_bank_map_asserts (
  .clk, .rst_n, .other_reset, .watchdog_clear_instr, .sleep_instr, .watchdog_timer_expired,
  .mem_addr, .mem_wr, .mem_wdata, .mem_rdata, .alu_valid, .alu_op, .alu_upd_zero,
  .alu_upd_carries, .alu_opa, .alu_opb, .alu_result, .arith_reset_flags
);

//--- dv/test_csf_status_bank_map.sv
// self-checking bench for the status flags and bank map
`timescale 1ns/1ps
module test_csf_status_bank_map;
  logic clk, rst_n, other_reset, other_reset_timeout, other_reset_powerdown, mem_wr, lin_wr;
  logic watchdog_clear_instr, sleep_instr, watchdog_timer_expired, alu_valid;
  logic alu_upd_zero, alu_upd_carries;
  logic [11:0] mem_addr;
  logic [9:0]  lin_addr;
  logic [7:0]  mem_wdata, lin_wdata, alu_opa, alu_opb, alu_logic_result;
  logic [7:0]  mem_rdata, lin_rdata, alu_result, arith_reset_flags;
  logic [4:0]  bank_select_reg;
  csf_pkg::csf_op_t alu_op;
  int          err_total = 0;
  int          n_compared = 0;
  // op, opa, opb, result, zero/nibble/carry
  localparam logic [28:0] ROWS [8] = '{{2'h0, 8'h0F, 8'h01, 8'h10, 3'h2},
    {2'h0, 8'h80, 8'h80, 8'h00, 3'h5}, {2'h1, 8'h10, 8'h01, 8'h0F, 3'h1},
    {2'h1, 8'h00, 8'h01, 8'hFF, 3'h0}, {2'h0, 8'hFF, 8'h01, 8'h00, 3'h7},
    {2'h2, 8'h00, 8'h00, 8'h00, 3'h7}, {2'h2, 8'h5A, 8'h00, 8'h5A, 3'h3},
    {2'h1, 8'h05, 8'h05, 8'h00, 3'h7}};
  csf_status_bank_map i_csf_status_bank_map (.clk, .rst_n, .other_reset, .other_reset_timeout,
    .other_reset_powerdown, .watchdog_clear_instr, .sleep_instr, .watchdog_timer_expired,
    .mem_addr, .mem_wr, .mem_wdata, .mem_rdata, .lin_addr, .lin_wr, .lin_wdata, .lin_rdata,
    .alu_valid, .alu_op, .alu_upd_zero, .alu_upd_carries, .alu_opa, .alu_opb,
    .alu_logic_result, .alu_result, .arith_reset_flags, .bank_select_reg);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic lin);
    @(negedge clk);
    {mem_addr, lin_addr, mem_wdata, lin_wdata} = {a, a[9:0], d, d};
    {mem_wr, lin_wr} = {!lin, lin};
    @(negedge clk);
    {mem_wr, lin_wr} = 2'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic lin);
    @(negedge clk);
    {mem_addr, lin_addr} = {a, a[9:0]};
    @(negedge clk);
    cmp8(lin ? "lin_rdata" : "mem_rdata", exp, lin ? lin_rdata : mem_rdata);
  endtask : rd
  task automatic alu(input logic [1:0] op, input logic [7:0] a, b, input logic w);
    @(negedge clk);
    alu_op = csf_pkg::csf_op_t'(op);
    {alu_opa, alu_opb, alu_logic_result} = {a, b, a};
    {mem_addr, mem_wdata, mem_wr, alu_valid} = {12'h003, 8'h00, w, 1'b1};
    @(negedge clk);
    {mem_wr, alu_valid} = 2'h0;
  endtask : alu
  task automatic ev(input logic [3:0] s, input logic [7:0] exp);
    @(negedge clk);
    {other_reset, watchdog_timer_expired, sleep_instr, watchdog_clear_instr} = s;
    @(negedge clk);
    {other_reset, watchdog_timer_expired, sleep_instr, watchdog_clear_instr} = 4'h0;
    cmp8("arith_reset_flags", exp, arith_reset_flags);
  endtask : ev
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : do_reset
  initial
  begin
    {other_reset, other_reset_timeout, other_reset_powerdown, watchdog_clear_instr} = 4'h0;
    {sleep_instr, watchdog_timer_expired, mem_wr, lin_wr, alu_valid} = 5'h00;
    {mem_addr, lin_addr, mem_wdata, lin_wdata, alu_opa, alu_opb, alu_logic_result} = '0;
    {alu_upd_zero, alu_upd_carries} = 2'h3;
    alu_op = csf_pkg::CSF_OP_ADD;
    do_reset();
    for (int i = 0; i < 8; i++)
    begin
      alu(ROWS[i][28:27], ROWS[i][26:19], ROWS[i][18:11], 1'b0);
      cmp8("alu_result", ROWS[i][10:3], alu_result);
      cmp8("arith_reset_flags", {5'h03, ROWS[i][2:0]},
           arith_reset_flags);
    end
    $display("alu rows done");
    wr(12'h003, 8'h00, 1'b0);
    cmp8("arith_reset_flags", 8'h18, arith_reset_flags);
    alu(2'h1, 8'h05, 8'h05, 1'b1);
    cmp8("arith_reset_flags", 8'h1F, arith_reset_flags);
    wr(12'hF83, 8'hE5, 1'b0);
    rd(12'h283, 8'h1D, 1'b0);
    $display("status writes done");
    ev(4'h2, 8'h15);
    ev(4'h4, 8'h05);
    ev(4'h1, 8'h1D);
    ev(4'h6, 8'h05);
    {other_reset_timeout, other_reset_powerdown} = 2'h2;
    wr(12'h008, 8'h0B, 1'b0);
    cmp8("bank_select_reg", 8'h0B, {3'h0, bank_select_reg});
    ev(4'h8, 8'h15);
    cmp8("bank_select_reg", 8'h00, {3'h0, bank_select_reg});
    {alu_upd_zero, alu_upd_carries} = 2'h0;
    alu(2'h0, 8'h05, 8'h05, 1'b1);
    cmp8("arith_reset_flags", 8'h10, arith_reset_flags);
    cmp8("alu_result", 8'h0A, alu_result);
    {alu_upd_zero, alu_upd_carries} = 2'h3;
    $display("event flags done");
    wr(12'h125, 8'hA7, 1'b0);
    rd(12'h0A5, 8'hA7, 1'b1);
    wr(12'h27F, 8'h3C, 1'b1);
    rd(12'h3EF, 8'h3C, 1'b0);
    rd(12'h280, 8'h00, 1'b1);
    wr(12'h07A, 8'h96, 1'b0);
    rd(12'h8FA, 8'h96, 1'b0);
    wr(12'h18C, 8'hFF, 1'b0);
    rd(12'h18C, 8'h00, 1'b0);
    wr(12'h420, 8'h55, 1'b0);
    rd(12'h420, 8'h00, 1'b0);
    $display("memory map done");
    do_reset();
    cmp8("arith_reset_flags", 8'h18, arith_reset_flags);
    $display("second reset done");
    tally_and_finish();
  end
  initial
  begin
    #20000;
    err_total++;
    tally_and_finish();
  end
endmodule : test_csf_status_bank_map

//--- verilog/csf_flag_alu.sv
// adder and flag generator for add, subtract and logic results
`timescale 1ns/1ps
module csf_flag_alu (
  input  wire logic            op_sub,
  input  wire logic            op_logic,
  input  wire logic [7:0]      opa,
  input  wire logic [7:0]      opb,
  input  wire logic [7:0]      logic_result,
  output logic      [7:0]      result,
  output logic                 zero,
  output logic                 nibble_carry,
  output logic                 carry
);
  logic [7:0] addend;
  logic [4:0] low_sum;
  logic [8:0] full_sum;

  always_comb
  begin
    // subtraction adds the two's complement; carries then mean no borrow
    addend   = op_sub ? ~opb : opb;
    low_sum  = {1'b0, opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, op_sub};
    full_sum = {1'b0, opa} + {1'b0, addend} + {8'h00, op_sub};
    result   = op_logic ? logic_result : full_sum[7:0];
    zero     = (result == 8'h00);
    nibble_carry = low_sum[4];
    carry    = full_sum[8];
  end
endmodule : csf_flag_alu

//--- verilog/csf_pkg.sv
// shared constants for the status flags and data memory map
package csf_pkg;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned BANK_W        = 5;
  localparam int unsigned OFS_W         = 7;
  localparam int unsigned NUM_BANKS     = 32;
  localparam int unsigned GPR_BYTES     = 80;
  localparam int unsigned GPR_BANKS     = 8;
  localparam int unsigned GPR_TOTAL     = GPR_BYTES * GPR_BANKS;
  localparam int unsigned LIN_W         = 10;
  localparam int unsigned COMMON_BYTES  = 16;
  localparam logic [6:0]  OFS_STATUS    = 7'h03;
  localparam logic [6:0]  OFS_BANK_SEL  = 7'h08;
  localparam logic [6:0]  OFS_CORE_LAST = 7'h0B;
  localparam logic [6:0]  OFS_PERI_FIRST = 7'h0C;
  localparam logic [6:0]  OFS_PERI_LAST = 7'h1F;
  localparam logic [6:0]  OFS_GPR_FIRST = 7'h20;
  localparam logic [6:0]  OFS_GPR_LAST  = 7'h6F;
  localparam logic [6:0]  OFS_COM_FIRST = 7'h70;
  localparam int unsigned BIT_TIMEOUT   = 4;
  localparam int unsigned BIT_POWERDOWN = 3;
  localparam int unsigned BIT_ZERO      = 2;
  localparam int unsigned BIT_NIBBLE    = 1;
  localparam int unsigned BIT_CARRY     = 0;
  localparam logic [1:0]  TOPD_RESET    = 2'h3;
  localparam logic [2:0]  ARITH_RESET   = 3'h0;
  localparam logic [4:0]  BANK_SEL_RESET = 5'h00;
  typedef enum logic [1:0] {
    CSF_OP_ADD,
    CSF_OP_SUB,
    CSF_OP_LOGIC
  } csf_op_t;
endpackage : csf_pkg

//--- verilog/csf_status_bank_map.sv
// status register, bank select and banked data memory with common and linear ram
// Overview of operation
// - status bits 7 to 5 always read zero; writes to them are dropped
// - timeout flag set by power-up, watchdog clear or sleep; cleared by watchdog timeout
// - powerdown flag set by power-up or watchdog clear; cleared by sleep
// - zero flag follows whether the operation result equals zero
// - nibble carry flag reports carry out of bit 3 for add and subtract
// - carry flag reports carry out of bit 7 for add and subtract
// - for subtraction both carries read one for no borrow, zero for borrow
// - subtraction adds the two's complement of the second operand
// - timeout, powerdown read-only reset to one; arithmetic flags writable, reset to zero
// - peripheral control area sits at offsets 0Ch to 1Fh in every bank
// - general ram of 80 bytes follows the peripheral area in ram banks
// - sixteen common ram bytes map to one store from every bank
// - general ram also reachable as one contiguous linear space
// - thirty-two banks, each starting with the same core registers
// - twelve-bit address, upper five bits bank, lower seven offset
// - flag-updating instruction writing status keeps flags from logic, not write
// - unimplemented locations read zero
`timescale 1ns/1ps
module csf_status_bank_map (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       other_reset,
  input  wire logic                       other_reset_timeout,
  input  wire logic                       other_reset_powerdown,
  input  wire logic                       watchdog_clear_instr,
  input  wire logic                       sleep_instr,
  input  wire logic                       watchdog_timer_expired,
  input  wire logic [csf_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic                       mem_wr,
  input  wire logic [7:0]                 mem_wdata,
  output logic      [7:0]                 mem_rdata,
  input  wire logic [csf_pkg::LIN_W-1:0]  lin_addr,
  input  wire logic                       lin_wr,
  input  wire logic [7:0]                 lin_wdata,
  output logic      [7:0]                 lin_rdata,
  input  wire logic                       alu_valid,
  input  wire csf_pkg::csf_op_t           alu_op,
  input  wire logic                       alu_upd_zero,
  input  wire logic                       alu_upd_carries,
  input  wire logic [7:0]                 alu_opa,
  input  wire logic [7:0]                 alu_opb,
  input  wire logic [7:0]                 alu_logic_result,
  output logic      [7:0]                 alu_result,
  output logic      [7:0]                 arith_reset_flags,
  output logic      [csf_pkg::BANK_W-1:0] bank_select_reg
);
  typedef struct packed {
    logic                       timeout;
    logic                       powerdown;
    logic                       zero;
    logic                       nibble_carry;
    logic                       carry;
    logic [csf_pkg::BANK_W-1:0] bank_sel;
    logic [7:0]                 rdata;
    logic [7:0]                 lin_rdata;
    logic [7:0]                 alu_result;
  } csf_state_t;

  csf_state_t state_q;
  csf_state_t state_d;
  logic       rst_sync1_q;
  logic       rst_sync2_q;
  // general ram is one flat array shared by the banked and linear ports
  logic [7:0] gpr_mem    [csf_pkg::GPR_TOTAL];
  logic [7:0] common_mem [csf_pkg::COMMON_BYTES];

  localparam int unsigned LIN_W = csf_pkg::LIN_W;

  logic [csf_pkg::BANK_W-1:0] bank;
  logic [csf_pkg::OFS_W-1:0]  ofs;
  logic                       is_gpr;
  logic                       is_common;
  logic [csf_pkg::LIN_W-1:0]  gpr_index;
  logic                       lin_ok;
  logic [7:0]                 status_view;
  logic [7:0]                 res;
  logic                       f_zero;
  logic                       f_nc;
  logic                       f_carry;

  // reset asserts at once but is released through two flops to avoid a release race
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end
    else
    begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  // one adder serves add and subtract; logic results only pass through
  csf_flag_alu u_alu (
    .op_sub       (alu_op == csf_pkg::CSF_OP_SUB),
    .op_logic     (alu_op == csf_pkg::CSF_OP_LOGIC),
    .opa          (alu_opa),
    .opb          (alu_opb),
    .logic_result (alu_logic_result),
    .result       (res),
    .zero         (f_zero),
    .nibble_carry (f_nc),
    .carry        (f_carry)
  );

  // address split and region decode
  always_comb
  begin
    bank      = mem_addr[csf_pkg::ADDR_W-1 -: csf_pkg::BANK_W];
    ofs       = mem_addr[csf_pkg::OFS_W-1:0];
    is_gpr    = (ofs >= csf_pkg::OFS_GPR_FIRST) && (ofs <= csf_pkg::OFS_GPR_LAST)
                && (32'(bank) < csf_pkg::GPR_BANKS);
    is_common = (ofs >= csf_pkg::OFS_COM_FIRST);
    gpr_index = LIN_W'(32'(bank) * csf_pkg::GPR_BYTES
                + 32'(ofs - csf_pkg::OFS_GPR_FIRST));
    lin_ok    = (32'(lin_addr) < csf_pkg::GPR_TOTAL);
    status_view = {3'h0, state_q.timeout, state_q.powerdown, state_q.zero,
                   state_q.nibble_carry, state_q.carry};
  end

  always_comb
  begin
    state_d = state_q;
    // writable arithmetic flags and bank select; same offsets in all 32 banks
    if (mem_wr && ofs == csf_pkg::OFS_STATUS)
    begin
      state_d.zero = mem_wdata[csf_pkg::BIT_ZERO];
      state_d.nibble_carry = mem_wdata[csf_pkg::BIT_NIBBLE];
      state_d.carry = mem_wdata[csf_pkg::BIT_CARRY];
    end
    if (mem_wr && ofs == csf_pkg::OFS_BANK_SEL)
    begin
      state_d.bank_sel = mem_wdata[csf_pkg::BANK_W-1:0];
    end
    // flag logic overrides any explicit write in the same cycle
    if (alu_valid)
    begin
      state_d.alu_result = res;
      if (alu_upd_zero)
      begin
        state_d.zero = f_zero;
      end
      if (alu_upd_carries && alu_op != csf_pkg::CSF_OP_LOGIC)
      begin
        state_d.nibble_carry = f_nc;
        state_d.carry = f_carry;
      end
    end
    if (watchdog_clear_instr)
    begin
      state_d.timeout = 1'b1;
      state_d.powerdown = 1'b1;
    end
    if (sleep_instr)
    begin
      state_d.timeout = 1'b1;
      state_d.powerdown = 1'b0;
    end
    if (watchdog_timer_expired)
    begin
      state_d.timeout = 1'b0;
    end
    if (other_reset)
    begin
      state_d.timeout = other_reset_timeout;
      state_d.powerdown = other_reset_powerdown;
      state_d.bank_sel = csf_pkg::BANK_SEL_RESET;
    end
    // registered read; anything not held here reads zero
    case (1'b1)
      (ofs == csf_pkg::OFS_STATUS): state_d.rdata = status_view;
      (ofs == csf_pkg::OFS_BANK_SEL): state_d.rdata = {3'h0, state_q.bank_sel};
      is_common: state_d.rdata = common_mem[ofs[3:0]];
      is_gpr: state_d.rdata = gpr_mem[gpr_index];
      default: state_d.rdata = 8'h00;
    endcase
    state_d.lin_rdata = lin_ok ? gpr_mem[lin_addr] : 8'h00;
  end

  always_ff @(posedge clk or negedge rst_sync2_q)
  begin
    if (!rst_sync2_q)
    begin
      state_q <= '0;
      {state_q.timeout, state_q.powerdown} <= csf_pkg::TOPD_RESET;
      {state_q.zero, state_q.nibble_carry, state_q.carry} <= csf_pkg::ARITH_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // storage; banked port wins over the linear port on the same byte
  always_ff @(posedge clk)
  begin
    if (lin_wr && lin_ok)
    begin
      gpr_mem[lin_addr] <= lin_wdata;
    end
    if (mem_wr && is_gpr && !is_common)
    begin
      gpr_mem[gpr_index] <= mem_wdata;
    end
    if (mem_wr && is_common)
    begin
      common_mem[ofs[3:0]] <= mem_wdata;
    end
  end

  assign mem_rdata         = state_q.rdata;
  assign lin_rdata         = state_q.lin_rdata;
  assign alu_result        = state_q.alu_result;
  assign arith_reset_flags = status_view;
  assign bank_select_reg   = state_q.bank_sel;
endmodule : csf_status_bank_map
